// [ltal_cmp_if.sv]
// Conversion sample path between the alert top and the trip filter
`timescale 1ns/1ps
interface ltal_cmp_if;
  logic        sample_valid;
  logic [15:0] sample;
  logic [15:0] low_limit;
  logic [15:0] high_limit;
  logic [1:0]  count_sel;
  logic        sample_done;
  logic        trip_high;
  logic        trip_low;

  modport top  (output sample_valid, sample, low_limit, high_limit, count_sel,
                input  sample_done, trip_high, trip_low);
  modport filt (input  sample_valid, sample, low_limit, high_limit, count_sel,
                output sample_done, trip_high, trip_low);
endinterface

// [ltal_conv_src.sv]
// Conversion engine model that drives the result link
`timescale 1ns/1ps
module ltal_conv_src (
  output logic        link_clk,
  output logic        conv_strobe,
  output logic [15:0] conv_data
);
  initial begin
    link_clk = 1'b0;
    conv_strobe = 1'b0;
    conv_data = 16'h5a5a;
  end
  // Link clock runs only inside a conversion frame
  task automatic send(input logic [15:0] d);
    conv_data = d;
    conv_strobe = 1'b1;
    #160;
    link_clk = 1'b1;
    #160;
    link_clk = 1'b0;
    conv_strobe = 1'b0;
    // Released code lines flip so a stale code never looks valid
    conv_data = ~d;
  endtask
endmodule

// [ltal_map.svh]
// Register offsets, field positions, reset values and counts of the light alert logic
`ifndef LTAL_MAP_SVH
`define LTAL_MAP_SVH

`define LTAL_ADDR_W        8
`define LTAL_DATA_W        32
`define LTAL_REG_W         16

`define LTAL_OFF_RESULT    8'h00
`define LTAL_OFF_CONFIG    8'h04
`define LTAL_OFF_LOW       8'h08
`define LTAL_OFF_HIGH      8'h0c
`define LTAL_OFF_ALERT_RSP 8'h10

`define LTAL_CFG_OPM_HI    10
`define LTAL_CFG_OPM_LO    9
`define LTAL_CFG_DONE      7
`define LTAL_CFG_ABOVE     6
`define LTAL_CFG_BELOW     5
`define LTAL_CFG_LATCH     4
`define LTAL_CFG_POL       3
`define LTAL_CFG_TRIP_HI   1
`define LTAL_CFG_TRIP_LO   0
`define LTAL_CFG_WMASK     16'hfe1f
`define LTAL_CFG_RESET     16'h0000
`define LTAL_LOW_RESET     16'h0000
`define LTAL_HIGH_RESET    16'hffff
`define LTAL_RESULT_RESET  16'h0000

`define LTAL_EXP_HI        15
`define LTAL_EXP_LO        12
`define LTAL_EOC_LO        14
`define LTAL_MANT_HI       11
`define LTAL_LIN_W         27
`define LTAL_LIN_PAD       15'h0000

`define LTAL_EOC_CODE      2'b11
`define LTAL_OPM_SHUTDOWN  2'b00

`define LTAL_ARA_ACK       0
`define LTAL_ARA_ABOVE     1

`define LTAL_TRIPS_SEL0    4'h1
`define LTAL_TRIPS_SEL1    4'h2
`define LTAL_TRIPS_SEL2    4'h4
`define LTAL_TRIPS_SEL3    4'h8

`define LTAL_SYNC_W        18

`endif

// [ltal_pkg.sv]
// Types shared by the light alert logic
package ltal_pkg;

  typedef enum logic [1:0] {
    LTAL_OUT_NONE = 2'b00,
    LTAL_OUT_HIGH = 2'b01,
    LTAL_OUT_LOW  = 2'b10
  } ltal_outcome_t;

  typedef enum logic [1:0] {
    LTAL_RESP_OKAY   = 2'b00,
    LTAL_RESP_SLVERR = 2'b10,
    LTAL_RESP_DECERR = 2'b11
  } ltal_resp_t;

endpackage

// [ltal_top.sv]
// Light threshold alert logic with AXI4-Lite registers and conversion link
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ltal_map.svh"
module ltal_top #(
  parameter int ADDR_W = `LTAL_ADDR_W,
  parameter int CNT_W  = 4
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output ltal_pkg::ltal_resp_t     s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output ltal_pkg::ltal_resp_t     s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                link_clk,
  input  wire logic                conv_strobe,
  input  wire logic [15:0]         conv_data,
  output logic                     alert_data,
  output logic                     alert_oe
);
  import ltal_pkg::*;

  ltal_cmp_if cmp ();

  // Link synchronisers: bit 17 clock, bit 16 strobe, low bits data
  logic [`LTAL_SYNC_W-1:0]  sync1_reg;
  logic [`LTAL_SYNC_W-1:0]  sync2_reg;
  logic                     link_clk_old_reg;
  logic                     sample_valid_reg;
  logic [15:0]              result_reg;

  logic [ADDR_W-1:0]        awaddr_reg;
  logic                     aw_held_reg;
  logic [31:0]              wdata_reg;
  logic [3:0]               wstrb_reg;
  logic                     w_held_reg;
  logic                     bvalid_reg;
  ltal_resp_t               bresp_reg;
  logic                     rvalid_reg;
  ltal_resp_t               rresp_reg;
  logic [31:0]              rdata_reg;
  logic [31:0]              rdata_next;
  ltal_resp_t               rresp_next;

  logic [15:0]              cfg_store_reg;
  logic [15:0]              low_reg;
  logic [15:0]              high_reg;
  logic                     above_limit_ind;
  logic                     below_limit_ind;
  logic                     conv_done_flag;
  logic                     alert_reg;
  logic                     alert_oe_reg;

  logic                     wr_fire;
  logic                     ar_fire;
  logic                     cfg_rd;
  logic                     cfg_wr;
  logic                     ara_rd;
  logic                     nonshut_wr;
  logic                     latch_fall;
  logic [1:0]               opm_new;
  logic                     latch_mode;
  logic                     alert_sense_sel;
  logic                     eoc_mode;
  logic [1:0]               low_limit_exponent_top;
  logic [1:0]               trip_count_sel;
  logic                     conv;
  logic                     th;
  logic                     tl;
  logic [15:0]              cfg_word;
  logic [15:0]              cfg_wr_word;

  // Byte-lane merge honouring write strobes and writable bits
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] data,
                                             input logic [3:0] strb, input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes      = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    lane_merge = (old & ~lanes) | (data[15:0] & lanes);
  endfunction

  // Conversion link sampled on clk; data is held stable for a link period
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg        <= '0;
      sync2_reg        <= '0;
      link_clk_old_reg <= 1'b0;
    end else begin
      sync1_reg        <= {link_clk, conv_strobe, conv_data};
      sync2_reg        <= sync1_reg;
      link_clk_old_reg <= sync2_reg[`LTAL_SYNC_W-1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sample_valid_reg <= 1'b0;
      result_reg       <= `LTAL_RESULT_RESET;
    end else begin
      sample_valid_reg <= sync2_reg[`LTAL_SYNC_W-1] && !link_clk_old_reg && sync2_reg[`LTAL_SYNC_W-2];
      if (sync2_reg[`LTAL_SYNC_W-1] && !link_clk_old_reg && sync2_reg[`LTAL_SYNC_W-2]) begin
        result_reg <= sync2_reg[15:0];
      end
    end
  end

  assign cmp.sample_valid = sample_valid_reg;
  assign cmp.sample       = result_reg;
  assign cmp.low_limit    = low_reg;
  assign cmp.high_limit   = high_reg;
  assign cmp.count_sel    = trip_count_sel;

  ltal_trip_filter #(
    .CNT_W (CNT_W)
  ) u_filter (
    .clk (clk),
    .rst (rst),
    .cmp (cmp)
  );

  assign conv = cmp.sample_done;
  assign th   = cmp.trip_high;
  assign tl   = cmp.trip_low;

  // Mode decode
  assign latch_mode             = cfg_store_reg[`LTAL_CFG_LATCH];
  assign alert_sense_sel        = cfg_store_reg[`LTAL_CFG_POL];
  assign trip_count_sel         = cfg_store_reg[`LTAL_CFG_TRIP_HI:`LTAL_CFG_TRIP_LO];
  assign low_limit_exponent_top = low_reg[`LTAL_EXP_HI:`LTAL_EOC_LO];
  assign eoc_mode               = low_limit_exponent_top == `LTAL_EOC_CODE;

  // AXI4-Lite handshakes: one write response and one read beat at a time
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_arready = !rvalid_reg;
  assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
  assign ar_fire       = s_axi_arvalid && !rvalid_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else if (s_axi_wvalid && !w_held_reg) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= LTAL_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      case (awaddr_reg)
        `LTAL_OFF_RESULT, `LTAL_OFF_CONFIG, `LTAL_OFF_LOW, `LTAL_OFF_HIGH, `LTAL_OFF_ALERT_RSP: begin
          bresp_reg <= LTAL_RESP_OKAY;
        end
        default: begin
          bresp_reg <= LTAL_RESP_DECERR;
        end
      endcase
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Access events that act on the flags
  assign cfg_rd      = ar_fire && s_axi_araddr == `LTAL_OFF_CONFIG;
  assign ara_rd      = ar_fire && s_axi_araddr == `LTAL_OFF_ALERT_RSP && latch_mode;
  assign cfg_wr      = wr_fire && awaddr_reg == `LTAL_OFF_CONFIG;
  assign cfg_wr_word = lane_merge(cfg_store_reg, wdata_reg, wstrb_reg, `LTAL_CFG_WMASK);
  assign opm_new     = cfg_wr_word[`LTAL_CFG_OPM_HI:`LTAL_CFG_OPM_LO];
  assign nonshut_wr  = cfg_wr && opm_new != `LTAL_OPM_SHUTDOWN;
  assign latch_fall  = cfg_wr && latch_mode && !cfg_wr_word[`LTAL_CFG_LATCH];

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_store_reg <= `LTAL_CFG_RESET;
    end else if (cfg_wr) begin
      cfg_store_reg <= cfg_wr_word;
    end
  end

  // Host must keep high above low; no ordering check here
  always_ff @(posedge clk) begin
    if (rst) begin
      low_reg  <= `LTAL_LOW_RESET;
      high_reg <= `LTAL_HIGH_RESET;
    end else if (wr_fire) begin
      if (awaddr_reg == `LTAL_OFF_LOW) begin
        low_reg <= lane_merge(low_reg, wdata_reg, wstrb_reg, '1);
      end
      if (awaddr_reg == `LTAL_OFF_HIGH) begin
        high_reg <= lane_merge(high_reg, wdata_reg, wstrb_reg, '1);
      end
    end
  end

  // Done flag: a finishing conversion beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_done_flag <= 1'b0;
    end else if (conv) begin
      conv_done_flag <= 1'b1;
    end else if (cfg_rd || nonshut_wr) begin
      conv_done_flag <= 1'b0;
    end
  end

  // Indicators; transparent mode ignores host accesses
  always_ff @(posedge clk) begin
    if (rst) begin
      above_limit_ind <= 1'b0;
    end else if (th) begin
      above_limit_ind <= 1'b1;
    end else if (tl && !latch_mode) begin
      above_limit_ind <= 1'b0;
    end else if (latch_mode && cfg_rd) begin
      above_limit_ind <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      below_limit_ind <= 1'b0;
    end else if (tl) begin
      below_limit_ind <= 1'b1;
    end else if (th && !latch_mode) begin
      below_limit_ind <= 1'b0;
    end else if (latch_mode && cfg_rd) begin
      below_limit_ind <= 1'b0;
    end
  end

  // Alert state; setting events win over clears in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_reg <= 1'b0;
    end else if (conv && (eoc_mode || th || (tl && latch_mode))) begin
      alert_reg <= 1'b1;
    end else if (tl && !latch_mode) begin
      alert_reg <= 1'b0;
    end else if (latch_fall && !eoc_mode) begin
      alert_reg <= 1'b0;
    end else if (latch_mode && (cfg_rd || ara_rd)) begin
      alert_reg <= 1'b0;
    end else if (eoc_mode && (cfg_rd || nonshut_wr)) begin
      alert_reg <= 1'b0;
    end
  end

  // Open drain: pull low when alert and sense disagree; one cycle behind state
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_oe_reg <= 1'b0;
    end else begin
      alert_oe_reg <= alert_reg ^ alert_sense_sel;
    end
  end

  assign alert_data = 1'b0;
  assign alert_oe = alert_oe_reg;

  // Config word as read; overflow bit is not produced here and reads zero
  always_comb begin
    cfg_word                  = cfg_store_reg;
    cfg_word[`LTAL_CFG_DONE]  = conv_done_flag;
    cfg_word[`LTAL_CFG_ABOVE] = above_limit_ind;
    cfg_word[`LTAL_CFG_BELOW] = below_limit_ind;
  end

  always_comb begin
    rdata_next = '0;
    rresp_next = LTAL_RESP_OKAY;
    case (s_axi_araddr)
      `LTAL_OFF_RESULT: begin
        rdata_next[15:0] = result_reg;
      end
      `LTAL_OFF_CONFIG: begin
        rdata_next[15:0] = cfg_word;
      end
      `LTAL_OFF_LOW: begin
        rdata_next[15:0] = low_reg;
      end
      `LTAL_OFF_HIGH: begin
        rdata_next[15:0] = high_reg;
      end
      `LTAL_OFF_ALERT_RSP: begin
        // Acknowledge only a latched, active alert; tells which limit tripped
        rdata_next[`LTAL_ARA_ACK]   = latch_mode && alert_reg;
        rdata_next[`LTAL_ARA_ABOVE] = latch_mode && alert_reg && above_limit_ind;
      end
      default: begin
        rresp_next = LTAL_RESP_DECERR;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= LTAL_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;
endmodule

// [ltal_top_properties.sv]
// Concurrent checks on the ports of the light alert top
`timescale 1ns/1ps
`include "ltal_map.svh"
module ltal_top_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              link_clk,
  input wire logic              alert_data,
  input wire logic              alert_oe
);
  logic       lat_reg, pol_reg, link_reg, act;
  logic [3:0] quiet_reg;
  // Shadow assumes address and data arrive together
  always_ff @(posedge clk) begin
    if (rst) begin
      lat_reg <= 1'b0;
      pol_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                 && s_axi_awaddr == `LTAL_OFF_CONFIG) begin
      lat_reg <= s_axi_wdata[`LTAL_CFG_LATCH];
      pol_reg <= s_axi_wdata[`LTAL_CFG_POL];
    end
  end
  assign act = (link_clk != link_reg) || (s_axi_arvalid && s_axi_arready) || s_axi_awvalid || s_axi_bvalid;
  always_ff @(posedge clk) begin
    link_reg <= link_clk;
    if (rst || act) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ar(a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  AST_DATA_LINE_LOW: assert property (!alert_data) else $error("alert data line not low");
  AST_RESET_PIN: assert property (disable iff (1'b0) rst |=> !alert_oe && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  AST_WRITE_ANSWER: assert property (s_wr_take |=> ##1 s_axi_bvalid) else $error("write response late");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_CFG_READ_CLEARS: assert property (s_ar(`LTAL_OFF_CONFIG) ##0 lat_reg |=> ##1 alert_oe == pol_reg)
    else $error("latched config read left alert active");
  AST_ARA_LATCHED: assert property (s_ar(`LTAL_OFF_ALERT_RSP) ##0 lat_reg |=> ##1 alert_oe == pol_reg)
    else $error("alert response left alert active");
  AST_ARA_TRANSPARENT: assert property (s_ar(`LTAL_OFF_ALERT_RSP) ##0 !lat_reg
    |=> s_axi_rdata[1:0] == 2'b00 ##1 $stable(alert_oe)) else $error("transparent alert response answered");
  AST_QUIET_PIN: assert property (quiet_reg == 4'hf |-> $stable(alert_oe))
    else $error("alert pin moved without cause");
endmodule

bind ltal_top ltal_top_checker #(.ADDR_W(ADDR_W)) chk (
  .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link_clk(link_clk),
  .alert_data(alert_data), .alert_oe(alert_oe));

// [ltal_top_tb_top.sv]
// Self-checking bench for the light alert top
`timescale 1ns/1ps
`include "ltal_map.svh"
module ltal_top_tb_top;
  import ltal_pkg::*;
  localparam logic [31:0] OPM = 32'h400, LAT = 32'h10, POLB = 32'h8, DN = 32'h80, AB = 32'h40, BE = 32'h20;
  localparam logic [15:0] HI = 16'h1200, LO = 16'h0001, MID = 16'h0080;
  localparam logic [7:0]  CFG = `LTAL_OFF_CONFIG, ARA = `LTAL_OFF_ALERT_RSP;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic        alert_data, alert_oe, link_clk, conv_strobe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0]  wstrb;
  logic [15:0] conv_data;
  logic [1:0]  rr;
  ltal_resp_t  bresp, rresp;
  int          mismatches, checks;

  ltal_conv_src src (.link_clk(link_clk), .conv_strobe(conv_strobe), .conv_data(conv_data));
  ltal_top #(.ADDR_W(8), .CNT_W(4)) dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_clk(link_clk), .conv_strobe(conv_strobe),
    .conv_data(conv_data), .alert_data(alert_data), .alert_oe(alert_oe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic results();
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Pin looked at mid-cycle; it lags the alert state by one flop
  task automatic chk_pin(input logic e);
    @(negedge clk);
    chk_data({31'h0, alert_oe}, {31'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rr = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    // Ready comes a cycle late so the slave must hold its read data
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (!rready) rready <= rvalid;
    end while (!(rvalid && rready));
    rdat = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk_data(rdat, e);
  endtask
  // Fixed wait covers link sync and flag update latency
  task automatic conv(input logic [15:0] d);
    src.send(d);
    repeat (10) @(posedge clk);
  endtask

  initial begin
    #200000;
    mismatches++;
    results();
  end
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk_pin(1'b0);
    rchk(CFG, 32'h0);
    rchk(`LTAL_OFF_HIGH, 32'hffff);
    wr(`LTAL_OFF_LOW, 32'h10);
    wr(`LTAL_OFF_HIGH, 32'h100);
    wr(CFG, OPM | 32'h1);
    conv(HI);
    chk_pin(1'b0);
    rchk(CFG, OPM | 32'h1 | DN);
    conv(HI);
    chk_pin(1'b1);
    rchk(CFG, OPM | 32'h1 | DN | AB);
    rchk(CFG, OPM | 32'h1 | AB);
    wr(CFG, OPM | 32'h1);
    chk_pin(1'b1);
    rchk(ARA, 32'h0);
    chk_pin(1'b1);
    conv(LO);
    conv(LO);
    chk_pin(1'b0);
    rchk(CFG, OPM | 32'h1 | DN | BE);
    conv(HI);
    conv(MID);
    conv(HI);
    chk_pin(1'b0);
    rchk(CFG, OPM | 32'h1 | DN | BE);
    rchk(`LTAL_OFF_RESULT, {16'h0, HI});
    wr(CFG, OPM | LAT);
    conv(HI);
    chk_pin(1'b1);
    rchk(ARA, 32'h3);
    chk_pin(1'b0);
    rchk(CFG, OPM | LAT | DN | AB | BE);
    rchk(CFG, OPM | LAT);
    wr(CFG, OPM | LAT | POLB);
    chk_pin(1'b1);
    wr(CFG, OPM | LAT);
    conv(LO);
    chk_pin(1'b1);
    wr(CFG, LAT);
    chk_pin(1'b1);
    rchk(CFG, LAT | DN | BE);
    chk_pin(1'b0);
    wr(CFG, OPM | LAT);
    conv(MID);
    chk_pin(1'b0);
    wr(CFG, OPM | LAT);
    rchk(CFG, OPM | LAT);
    wr(`LTAL_OFF_LOW, 32'hc000);
    conv(MID);
    chk_pin(1'b1);
    rchk(CFG, OPM | LAT | DN);
    chk_pin(1'b0);
    conv(MID);
    wr(CFG, OPM | LAT);
    chk_pin(1'b0);
    conv(MID);
    rchk(ARA, 32'h1);
    chk_pin(1'b0);
    wr(CFG, OPM);
    conv(HI);
    chk_pin(1'b1);
    rchk(ARA, 32'h0);
    chk_pin(1'b1);
    rchk(CFG, OPM | DN | AB);
    chk_pin(1'b0);
    conv(MID);
    wr(CFG, OPM);
    chk_pin(1'b0);
    wr(CFG, OPM | LAT);
    conv(MID);
    wr(`LTAL_OFF_LOW, 32'h10);
    chk_pin(1'b1);
    wr(CFG, OPM);
    chk_pin(1'b0);
    chk_data({30'h0, rr}, 32'h0);
    rd(8'h20);
    chk_data({30'h0, rr}, 32'h3);
    chk_data(rdat, 32'h0);
    wr(8'h20, 32'h0);
    chk_data({30'h0, rr}, 32'h3);
    results();
  end
endmodule

// [ltal_trip_filter.sv]
// Limit comparison and consecutive trip counting of each conversion
`timescale 1ns/1ps
`include "ltal_map.svh"
module ltal_trip_filter #(
  parameter int CNT_W = 4
) (
  input wire logic clk,
  input wire logic rst,
  ltal_cmp_if.filt cmp
);
  import ltal_pkg::*;

  ltal_outcome_t                outcome;
  ltal_outcome_t                last_reg;
  logic [CNT_W-1:0]             run_reg;
  logic [CNT_W-1:0]             run_next;
  logic [CNT_W-1:0]             need;
  logic [`LTAL_LIN_W-1:0]       val_lin;
  logic [`LTAL_LIN_W-1:0]       low_lin;
  logic [`LTAL_LIN_W-1:0]       high_lin;
  logic                         done_reg;
  logic                         high_reg;
  logic                         low_reg;

  // Exponent and mantissa to one linear scale so codes compare honestly
  function automatic logic [`LTAL_LIN_W-1:0] to_linear(input logic [15:0] code);
    to_linear = {`LTAL_LIN_PAD, code[`LTAL_MANT_HI:0]} << code[`LTAL_EXP_HI:`LTAL_EXP_LO];
  endfunction

  assign val_lin  = to_linear(cmp.sample);
  assign low_lin  = to_linear(cmp.low_limit);
  assign high_lin = to_linear(cmp.high_limit);

  always_comb begin
    case (cmp.count_sel)
      2'b00:   need = CNT_W'(`LTAL_TRIPS_SEL0);
      2'b01:   need = CNT_W'(`LTAL_TRIPS_SEL1);
      2'b10:   need = CNT_W'(`LTAL_TRIPS_SEL2);
      default: need = CNT_W'(`LTAL_TRIPS_SEL3);
    endcase
  end

  always_comb begin
    if (val_lin > high_lin) begin
      outcome = LTAL_OUT_HIGH;
    end else if (val_lin < low_lin) begin
      outcome = LTAL_OUT_LOW;
    end else begin
      outcome = LTAL_OUT_NONE;
    end
  end

  // Restart on a changed outcome or a clean sample; saturate at the need
  always_comb begin
    if (outcome == LTAL_OUT_NONE) begin
      run_next = '0;
    end else if (outcome != last_reg) begin
      run_next = CNT_W'(1);
    end else if (run_reg < need) begin
      run_next = run_reg + CNT_W'(1);
    end else begin
      run_next = run_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      run_reg  <= '0;
      last_reg <= LTAL_OUT_NONE;
    end else if (cmp.sample_valid) begin
      run_reg  <= run_next;
      last_reg <= outcome;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_reg <= 1'b0;
      high_reg <= 1'b0;
      low_reg  <= 1'b0;
    end else begin
      done_reg <= cmp.sample_valid;
      high_reg <= cmp.sample_valid && outcome == LTAL_OUT_HIGH && run_next >= need;
      low_reg  <= cmp.sample_valid && outcome == LTAL_OUT_LOW && run_next >= need;
    end
  end

  assign cmp.sample_done = done_reg;
  assign cmp.trip_high   = high_reg;
  assign cmp.trip_low    = low_reg;
endmodule
